// ### hdl/rtcm_pkg.sv
package rtcm_pkg;

  // ------------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------------
  localparam int CLK_MHZ       = 50;
  localparam int LOSS_TIME_US  = 100;
  localparam int LOSS_CYC      = LOSS_TIME_US * CLK_MHZ;
  localparam int BLANK_TIME_MS = 2;
  localparam int BLANK_CYC     = BLANK_TIME_MS * 1000 * CLK_MHZ;

  // ------------------------------------------------------------------
  // Widths
  // ------------------------------------------------------------------
  localparam int ADDR_W  = 4;
  localparam int DATA_W  = 8;
  localparam int TIMER_W = 32;
  localparam int BYTES   = TIMER_W / DATA_W;

  // ------------------------------------------------------------------
  // Register offsets
  // ------------------------------------------------------------------
  localparam logic [ADDR_W-1:0] ADR_CAP0 = 4'h0;
  localparam logic [ADDR_W-1:0] ADR_CTRL = 4'h4;
  localparam logic [ADDR_W-1:0] ADR_OSC  = 4'h5;
  localparam logic [ADDR_W-1:0] ADR_ALM0 = 4'h8;

  // ------------------------------------------------------------------
  // Control register fields
  // ------------------------------------------------------------------
  localparam int CTL_OSC_EN  = 7;
  localparam int CTL_LOSS_EN = 6;
  localparam int CTL_FAIL    = 5;
  localparam int CTL_RUN     = 4;
  localparam int CTL_AEN     = 3;
  localparam int CTL_ALARM   = 2;
  localparam int CTL_LOAD    = 1;
  localparam int CTL_SNAP    = 0;

  // ------------------------------------------------------------------
  // Oscillator control register fields and reset values
  // ------------------------------------------------------------------
  localparam int OSC_XVALID = 4;
  localparam logic [DATA_W-1:0] OSC_RST  = 8'h00;
  localparam logic [DATA_W-1:0] BYTE_RST = 8'h00;

endpackage

// ### hdl/rtcm_sync.sv
`timescale 1ns/1ps
module rtcm_sync (
  input  wire logic CLK,      // System clock
  input  wire logic SYS_RST,  // Synchronous reset, active high
  input  wire logic async_in, // Level from outside the clock domain
  output logic      lvl,      // Synchronised level
  output logic      rise,     // One-cycle pulse on a rising edge
  output logic      edge_any  // One-cycle pulse on either edge
);

  logic meta_r;
  logic sync_r;
  logic prev_r;

  // Two flops first; only sync_r and later are looked at
  always_ff @(posedge CLK)
  begin
    if (SYS_RST)
    begin
      meta_r <= 1'b0;
      sync_r <= 1'b0;
      prev_r <= 1'b0;
    end
    else
    begin
      meta_r <= async_in;
      sync_r <= meta_r;
      prev_r <= sync_r;
    end
  end

  assign lvl      = sync_r;
  assign rise     = sync_r & ~prev_r;
  assign edge_any = sync_r ^ prev_r;

endmodule

// ### hdl/rtcm_loss.sv
`timescale 1ns/1ps
module rtcm_loss #(
  parameter int unsigned LIMIT = rtcm_pkg::LOSS_CYC // Cycles without edge
) (
  input  wire logic CLK,      // System clock
  input  wire logic SYS_RST,  // Synchronous reset, active high
  input  wire logic en,       // Detector armed
  input  wire logic edge_any, // Synchronised oscillator edge
  output logic      fire      // One-cycle pulse on timeout
);

  localparam int CW = $clog2(LIMIT + 1);
  localparam logic [CW-1:0] LIM = CW'(LIMIT);

  logic [CW-1:0] cnt_r;
  logic          fire_r;
  logic          done;

  // One-shot: saturates at the limit and waits for a fresh edge
  assign done = (cnt_r == LIM);

  // Count cycles since the last level change of the oscillator
  always_ff @(posedge CLK)
  begin
    if (SYS_RST || !en || edge_any)
      cnt_r <= '0;
    else if (!done)
      cnt_r <= cnt_r + 1'b1;
  end

  // Pulse once, in the cycle the count reaches the limit
  always_ff @(posedge CLK)
  begin
    if (SYS_RST)
      fire_r <= 1'b0;
    else
      fire_r <= en && !edge_any && (cnt_r == LIM - 1'b1);
  end

  assign fire = fire_r;

endmodule

// ### hdl/rtcm_top.sv
// How it works
// - With detector on, a stuck oscillator level over 100 us sets the fail flag.
// - A clock-loss timeout is an event output for interrupt, wake or reset.
// - A read-only crystal-valid bit shows the amplitude detector output.
// - Crystal-valid reads invalid for 2 ms after the oscillator turns on.
// - 32-bit timer counts each slow cycle while run is 1, else holds.
// - The alarm event is an output for interrupt, wake or reset.
// - With auto-reset, timer clears on the same slow tick that the alarm deasserts.
// - Writing 1 to the alarm bit of control enables auto-reset.
// - Timer is loaded and read through capture registers while running.
// - Load request copies capture into timer, then hardware clears it.
// - Snapshot request copies timer into capture, then hardware clears it.
// - Alarm fires when the whole timer equals the whole match value.
// - Writing 0 to alarm-enable clears the alarm event flag.
// - Without auto-reset the timer runs on; next match after 2^32 cycles.
// - Alarm flag stays up at most one slow cycle.
// - Timer wraps freely; software adds intervals with 32-bit wrap.
// - Fail flag is set only by hardware and cleared only by software.
// - Control bit 7 switches the slow oscillator and its bias on or off.
//
// Implementation choices: the register offsets and the plain strobed port.
`timescale 1ns/1ps
module rtcm_top #(
  parameter int unsigned LOSS_CYCLES  = rtcm_pkg::LOSS_CYC,  // Stuck limit
  parameter int unsigned BLANK_CYCLES = rtcm_pkg::BLANK_CYC  // Blanking
) (
  input  wire logic                       CLK,       // 50 MHz clock
  input  wire logic                       SYS_RST,   // Sync reset, high
  input  wire logic [rtcm_pkg::ADDR_W-1:0] ADDR,     // Register address
  input  wire logic [rtcm_pkg::DATA_W-1:0] WR_DATA,  // Write data
  input  wire logic                       WR_EN,     // Write strobe
  input  wire logic                       RD_EN,     // Read strobe
  output logic      [rtcm_pkg::DATA_W-1:0] RD_DATA,  // Read data, +1 cycle
  input  wire logic                       OSC_CLK_IN, // Slow osc output
  input  wire logic                       XTAL_AMP_IN, // Amplitude ok
  output logic                            OSC_ENABLE, // Osc and bias on
  output logic      [rtcm_pkg::DATA_W-1:0] OSC_CTRL, // Osc settings
  output logic                            ALARM_EVENT, // Alarm flag
  output logic                            CLOCK_LOSS_EVENT // Loss pulse
);

  localparam int TW = rtcm_pkg::TIMER_W;
  localparam int DW = rtcm_pkg::DATA_W;
  localparam int NB = rtcm_pkg::BYTES;
  localparam int BW = $clog2(BLANK_CYCLES + 1);
  localparam logic [BW-1:0] BLANK_END = BW'(BLANK_CYCLES);

  // ------------------------------------------------------------------
  // State
  // ------------------------------------------------------------------
  logic [TW-1:0] timer_r;
  logic [TW-1:0] timer_nxt;
  logic [DW-1:0] cap_r [NB];
  logic [DW-1:0] alm_r [NB];
  logic [DW-1:0] osc_ctl_r;
  logic [DW-1:0] rd_r;
  logic [BW-1:0] blank_r;
  logic          osc_en_r;
  logic          loss_en_r;
  logic          fail_r;
  logic          fail_nxt;
  logic          run_r;
  logic          aen_r;
  logic          autorst_r;
  logic          flag_r;
  logic          flag_nxt;
  logic          arm;
  logic          load_r;
  logic          load_nxt;
  logic          snap_r;
  logic          snap_nxt;
  logic          loss_evt_r;

  // ------------------------------------------------------------------
  // Input synchronisers and clock-loss detector
  // ------------------------------------------------------------------
  logic osc_rise;
  logic osc_edge;
  logic amp_lvl;
  logic loss_fire;
  logic tick;

  rtcm_sync u_osc_sync (
    .CLK      (CLK),
    .SYS_RST  (SYS_RST),
    .async_in (OSC_CLK_IN),
    .lvl      (),
    .rise     (osc_rise),
    .edge_any (osc_edge)
  );

  rtcm_sync u_amp_sync (
    .CLK      (CLK),
    .SYS_RST  (SYS_RST),
    .async_in (XTAL_AMP_IN),
    .lvl      (amp_lvl),
    .rise     (),
    .edge_any ()
  );

  // Detector only armed while the oscillator is powered
  rtcm_loss #(
    .LIMIT (LOSS_CYCLES)
  ) u_loss (
    .CLK      (CLK),
    .SYS_RST  (SYS_RST),
    .en       (loss_en_r & osc_en_r),
    .edge_any (osc_edge),
    .fire     (loss_fire)
  );

  // One slow-oscillator cycle, as an enable in the CLK domain
  assign tick = osc_rise & osc_en_r;

  // ------------------------------------------------------------------
  // Address decode
  // ------------------------------------------------------------------
  wire wr_ctrl = WR_EN && (ADDR == rtcm_pkg::ADR_CTRL);
  wire wr_osc  = WR_EN && (ADDR == rtcm_pkg::ADR_OSC);
  wire aen_off = wr_ctrl && !WR_DATA[rtcm_pkg::CTL_AEN];
  wire [TW-1:0] cap_word = {cap_r[3], cap_r[2], cap_r[1], cap_r[0]};
  wire [TW-1:0] alm_word = {alm_r[3], alm_r[2], alm_r[1], alm_r[0]};
  wire blank_done = (blank_r == BLANK_END);
  wire xvalid     = amp_lvl & blank_done;
  // Full-width compare; both values wrap alike, so no overflow case
  wire match      = run_r & aen_r
                  & (timer_r == alm_word);

  // ------------------------------------------------------------------
  // Timer next value
  // ------------------------------------------------------------------
  // Load beats auto-reset so a software load is never thrown away
  assign timer_nxt = !tick  ? timer_r :
                     load_r ? cap_word :
                     arm    ? '0 :
                     run_r  ? timer_r + 32'h1 :
                              timer_r;

  // Flags: hardware sets win over software clears, except alarm disable
  assign flag_nxt = aen_off ? 1'b0 : (tick ? match : flag_r);
  // Clearing on the tick that drops the alarm keeps the period at match+2
  assign arm      = flag_r & autorst_r;
  assign load_nxt = (wr_ctrl & WR_DATA[rtcm_pkg::CTL_LOAD])
                  | (load_r & !tick);
  assign snap_nxt = (wr_ctrl & WR_DATA[rtcm_pkg::CTL_SNAP])
                  | (snap_r & !tick);
  assign fail_nxt = loss_fire
                  | (fail_r & !(wr_ctrl & !WR_DATA[rtcm_pkg::CTL_FAIL]));

  // ------------------------------------------------------------------
  // Control and timer registers
  // ------------------------------------------------------------------
  always_ff @(posedge CLK)
  begin
    if (SYS_RST)
    begin
      timer_r    <= '0;
      flag_r     <= 1'b0;
      load_r     <= 1'b0;
      snap_r     <= 1'b0;
      fail_r     <= 1'b0;
      loss_evt_r <= 1'b0;
    end
    else
    begin
      timer_r    <= timer_nxt;
      flag_r     <= flag_nxt;
      load_r     <= load_nxt;
      snap_r     <= snap_nxt;
      fail_r     <= fail_nxt;
      loss_evt_r <= loss_fire;
    end
  end

  // Software-owned control bits; bit 2 written means auto-reset
  always_ff @(posedge CLK)
  begin
    if (SYS_RST)
    begin
      osc_en_r  <= 1'b0;
      loss_en_r <= 1'b0;
      run_r     <= 1'b0;
      aen_r     <= 1'b0;
      autorst_r <= 1'b0;
      osc_ctl_r <= rtcm_pkg::OSC_RST;
    end
    else
    begin
      if (wr_ctrl)
      begin
        osc_en_r  <= WR_DATA[rtcm_pkg::CTL_OSC_EN];
        loss_en_r <= WR_DATA[rtcm_pkg::CTL_LOSS_EN];
        run_r     <= WR_DATA[rtcm_pkg::CTL_RUN];
        aen_r     <= WR_DATA[rtcm_pkg::CTL_AEN];
        autorst_r <= WR_DATA[rtcm_pkg::CTL_ALARM];
      end
      if (wr_osc)
        osc_ctl_r <= WR_DATA & ~(8'h01 << rtcm_pkg::OSC_XVALID);
    end
  end

  // Blanking counter restarts every time the oscillator is switched on
  always_ff @(posedge CLK)
  begin
    if (SYS_RST || !osc_en_r)
      blank_r <= '0;
    else if (!blank_done)
      blank_r <= blank_r + 1'b1;
  end

  // ------------------------------------------------------------------
  // Capture and alarm byte registers
  // ------------------------------------------------------------------
  // A snapshot on the same cycle as a software write wins the byte
  for (genvar i = 0; i < NB; i++)
  begin : g_byte
    wire wr_cap = WR_EN && (ADDR == rtcm_pkg::ADR_CAP0 + 4'(i));
    wire wr_alm = WR_EN && (ADDR == rtcm_pkg::ADR_ALM0 + 4'(i));
    always_ff @(posedge CLK)
    begin
      if (SYS_RST)
      begin
        cap_r[i] <= rtcm_pkg::BYTE_RST;
        alm_r[i] <= rtcm_pkg::BYTE_RST;
      end
      else
      begin
        if (tick && snap_r)
          cap_r[i] <= timer_r[i*DW +: DW];
        else if (wr_cap)
          cap_r[i] <= WR_DATA;
        if (wr_alm)
          alm_r[i] <= WR_DATA;
      end
    end
  end

  // ------------------------------------------------------------------
  // Read path
  // ------------------------------------------------------------------
  wire [DW-1:0] ctrl_rd = {osc_en_r, loss_en_r, fail_r, run_r,
                           aen_r, flag_r, load_r, snap_r};
  wire [DW-1:0] osc_rd  = osc_ctl_r | (DW'(xvalid) << rtcm_pkg::OSC_XVALID);
  localparam int ADDR_LO_W = 2;
  wire [ADDR_LO_W-1:0] unused_lo;
  assign unused_lo = ADDR[ADDR_LO_W-1:0];
  wire [DW-1:0] rd_mux =
    (ADDR[3:2] == 2'h0)             ? cap_r[unused_lo] :
    (ADDR[3:2] == 2'h2)             ? alm_r[unused_lo] :
    (ADDR == rtcm_pkg::ADR_CTRL)    ? ctrl_rd :
    (ADDR == rtcm_pkg::ADR_OSC)     ? osc_rd :
                                      8'h00;

  // Data stand only in the cycle after the strobe; unmapped reads zero
  always_ff @(posedge CLK)
  begin
    if (SYS_RST)
      rd_r <= 8'h00;
    else
      rd_r <= RD_EN ? rd_mux : 8'h00;
  end

  assign RD_DATA          = rd_r;
  assign OSC_ENABLE       = osc_en_r;
  assign OSC_CTRL         = osc_ctl_r;
  assign ALARM_EVENT      = flag_r;
  assign CLOCK_LOSS_EVENT = loss_evt_r;

  // ------------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------------
  default clocking cb @(posedge CLK); endclocking
  default disable iff (SYS_RST);

  // Auto-reset: the tick that ends the alarm also zeroes the timer
  sequence alarm_hit_s;
    tick && flag_r && autorst_r && !load_r;
  endsequence
  sequence cleared_s;
    (timer_r == 32'h0) && !flag_r;
  endsequence

  timer_hold_a: assert property (
    tick && !run_r && !load_r && !arm |=> $stable(timer_r))
    else $error("Timer moved while stopped");
  timer_inc_a: assert property (
    tick && run_r && !load_r && !arm |=> timer_r == $past(timer_r) + 1)
    else $error("Timer did not count by one");
  alarm_set_a: assert property (
    tick && match && !aen_off |=> flag_r)
    else $error("Match did not raise alarm");
  alarm_short_a: assert property (
    flag_r && tick && !match |=> !flag_r)
    else $error("Alarm flag outlived one slow cycle");
  auto_clear_a: assert property (
    alarm_hit_s |=> cleared_s)
    else $error("Auto-reset did not clear timer and flag");
  auto_zero_a: assert property (
    tick && arm && !load_r |=> timer_r == 32'h0)
    else $error("Timer not cleared after alarm");
  load_done_a: assert property (
    tick && load_r && !wr_ctrl |=> timer_r == $past(cap_word) && !load_r)
    else $error("Load did not complete");
  snap_done_a: assert property (
    tick && snap_r && !wr_ctrl |=> cap_word == $past(timer_r) && !snap_r)
    else $error("Snapshot did not complete");
  aen_clear_a: assert property (
    aen_off |=> !flag_r)
    else $error("Alarm disable left flag set");
  fail_set_a: assert property (
    loss_fire |=> fail_r && CLOCK_LOSS_EVENT)
    else $error("Clock loss not flagged");
  blank_a: assert property (
    !blank_done |-> !osc_rd[rtcm_pkg::OSC_XVALID])
    else $error("Crystal valid seen in blanking");
  osc_en_a: assert property (
    wr_ctrl |=> OSC_ENABLE == $past(WR_DATA[rtcm_pkg::CTL_OSC_EN]))
    else $error("Oscillator enable not written");

endmodule

// ### tb/rtcm_top_bench.sv
`timescale 1ns/1ps
module rtcm_top_bench;

  // ------------------------------------------------------------------
  // Constants and signals
  // ------------------------------------------------------------------
  localparam int unsigned LOSS_N  = 50;  // Short stuck limit keeps run brief
  localparam int unsigned BLANK_N = 20;  // Short blanking keeps run brief
  localparam logic [7:0] B_OSC  = 8'h01 << rtcm_pkg::CTL_OSC_EN;
  localparam logic [7:0] B_LOSS = 8'h01 << rtcm_pkg::CTL_LOSS_EN;
  localparam logic [7:0] B_FAIL = 8'h01 << rtcm_pkg::CTL_FAIL;
  localparam logic [7:0] B_RUN  = 8'h01 << rtcm_pkg::CTL_RUN;
  localparam logic [7:0] B_AEN  = 8'h01 << rtcm_pkg::CTL_AEN;
  localparam logic [7:0] B_ALM  = 8'h01 << rtcm_pkg::CTL_ALARM;
  localparam logic [7:0] B_LOAD = 8'h01 << rtcm_pkg::CTL_LOAD;
  localparam logic [7:0] B_SNAP = 8'h01 << rtcm_pkg::CTL_SNAP;
  localparam logic [7:0] B_XV   = 8'h01 << rtcm_pkg::OSC_XVALID;

  logic        clk;
  logic        sys_rst;
  logic [3:0]  addr;
  logic [7:0]  wdata;
  logic        wr_en;
  logic        rd_en;
  logic [7:0]  rdata;
  logic        osc_in;
  logic        xtal_amp;
  logic        osc_en;
  logic [7:0]  osc_ctrl;
  logic        alarm;
  logic        loss;
  logic [7:0]  d;
  logic [31:0] v;
  int          num_errors;
  int          checked;
  int          alarm_rises;
  int          hi_len;
  int          hi_max;
  int          loss_pulses;
  int          n;

  rtcm_top #(
    .LOSS_CYCLES  (LOSS_N),
    .BLANK_CYCLES (BLANK_N)
  ) i_rtcm_top (
    .CLK              (clk),
    .SYS_RST          (sys_rst),
    .ADDR             (addr),
    .WR_DATA          (wdata),
    .WR_EN            (wr_en),
    .RD_EN            (rd_en),
    .RD_DATA          (rdata),
    .OSC_CLK_IN       (osc_in),
    .XTAL_AMP_IN      (xtal_amp),
    .OSC_ENABLE       (osc_en),
    .OSC_CTRL         (osc_ctrl),
    .ALARM_EVENT      (alarm),
    .CLOCK_LOSS_EVENT (loss)
  );

  // 50 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // Event monitor: alarm pulse count and width, loss pulse count
  always @(posedge clk)
  begin
    if (alarm === 1'b1)
    begin
      hi_len <= hi_len + 1;
      if (hi_len == 0) alarm_rises <= alarm_rises + 1;
      if (hi_len + 1 > hi_max) hi_max <= hi_len + 1;
    end
    else
      hi_len <= 0;
    if (loss === 1'b1) loss_pulses <= loss_pulses + 1;
  end

  // ------------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------------
  task automatic test_done();
    $display("checks %0d, errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      num_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] dv);
    @(posedge clk);
    addr  <= a;
    wdata <= dv;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
    #1;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, output logic [7:0] dv);
    @(posedge clk);
    addr  <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1;
    dv = rdata;
  endtask

  // One slow cycle is eight system clocks; ends off the edge
  task automatic tick(input int k);
    repeat (k)
    begin
      @(posedge clk);
      osc_in <= 1'b1;
      repeat (4) @(posedge clk);
      osc_in <= 1'b0;
      repeat (3) @(posedge clk);
    end
    #1;
  endtask

  task automatic put32(input logic [3:0] base, input logic [31:0] x);
    for (int i = 0; i < 4; i++) wr(base + 4'(i), x[8*i +: 8]);
  endtask

  task automatic get32(input logic [3:0] base, output logic [31:0] x);
    logic [7:0] b;
    for (int i = 0; i < 4; i++)
    begin
      rd(base + 4'(i), b);
      x[8*i +: 8] = b;
    end
  endtask

  // Request bit must stay up until the next slow tick
  task automatic load(input logic [31:0] x, input logic [7:0] c);
    put32(rtcm_pkg::ADR_CAP0, x);
    wr(rtcm_pkg::ADR_CTRL, c | B_LOAD);
    rd(rtcm_pkg::ADR_CTRL, d);
    chk(d & B_LOAD, B_LOAD);
    tick(1);
    rd(rtcm_pkg::ADR_CTRL, d);
    chk(d & B_LOAD, 8'h00);
  endtask

  task automatic snap(input logic [7:0] c, output logic [31:0] x);
    wr(rtcm_pkg::ADR_CTRL, c | B_SNAP);
    tick(1);
    rd(rtcm_pkg::ADR_CTRL, d);
    chk(d & B_SNAP, 8'h00);
    get32(rtcm_pkg::ADR_CAP0, x);
  endtask

  // ------------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------------
  initial
  begin
    sys_rst  = 1'b1;
    addr     = 4'h0;
    wdata    = 8'h00;
    wr_en    = 1'b0;
    rd_en    = 1'b0;
    osc_in   = 1'b0;
    xtal_amp = 1'b1;
    repeat (10) @(posedge clk);
    sys_rst <= 1'b0;
    // Reset state, unmapped places read zero
    rd(rtcm_pkg::ADR_CTRL, d);
    chk(d, 8'h00);
    chk(osc_en, 1'b0);
    wr(4'hf, 8'hff);
    rd(4'hf, d);
    chk(d, 8'h00);
    // Crystal valid is held low while blanking runs
    wr(rtcm_pkg::ADR_CTRL, B_OSC);
    rd(rtcm_pkg::ADR_OSC, d);
    chk(d & B_XV, 8'h00);
    chk(osc_en, 1'b1);
    repeat (BLANK_N + 10) @(posedge clk);
    rd(rtcm_pkg::ADR_OSC, d);
    chk(d & B_XV, B_XV);
    wr(rtcm_pkg::ADR_OSC, 8'hff);
    chk(osc_ctrl, 8'hef);
    xtal_amp <= 1'b0;
    repeat (5) @(posedge clk);
    rd(rtcm_pkg::ADR_OSC, d);
    chk(d, 8'hef);
    @(posedge clk);
    #1;
    chk(rdata, 8'h00);
    wr(rtcm_pkg::ADR_OSC, 8'h00);
    // Load while running, count five, then hold while stopped
    load(32'h1234_5678, B_OSC | B_RUN);
    tick(5);
    wr(rtcm_pkg::ADR_CTRL, B_OSC);
    snap(B_OSC, v);
    chk(v, 32'h1234_567d);
    tick(3);
    snap(B_OSC, v);
    chk(v, 32'h1234_567d);
    // Overflow wraps to zero
    load(32'hffff_fffe, B_OSC | B_RUN);
    tick(3);
    wr(rtcm_pkg::ADR_CTRL, B_OSC);
    snap(B_OSC, v);
    chk(v, 32'h0000_0001);
    // Match advanced by wrapping addition is met past the overflow
    put32(rtcm_pkg::ADR_ALM0, 32'hffff_fffe + 32'h5);
    load(32'hffff_fffe, B_OSC | B_RUN | B_AEN);
    n = alarm_rises;
    tick(5);
    chk(alarm_rises - n, 0);
    tick(1);
    chk(alarm_rises - n, 1);
    wr(rtcm_pkg::ADR_CTRL, B_OSC);
    // Alarm on equality, cleared by alarm disable
    put32(rtcm_pkg::ADR_ALM0, 32'h0000_0005);
    load(32'h0, B_OSC);
    wr(rtcm_pkg::ADR_CTRL, B_OSC | B_RUN | B_AEN);
    n = 0;
    while (n < 10 && alarm !== 1'b1)
    begin
      tick(1);
      n++;
    end
    chk(n >= 5 && n <= 6, 1'b1);
    rd(rtcm_pkg::ADR_CTRL, d);
    chk(d & B_ALM, B_ALM);
    wr(rtcm_pkg::ADR_CTRL, B_OSC | B_RUN);
    @(posedge clk);
    #1;
    chk(alarm, 1'b0);
    // Re-enable with the same match: nothing for a long time
    n = alarm_rises;
    wr(rtcm_pkg::ADR_CTRL, B_OSC | B_RUN | B_AEN);
    tick(22);
    chk(alarm_rises - n, 0);
    // Auto-reset gives a period of match plus two
    wr(rtcm_pkg::ADR_CTRL, B_OSC | B_RUN);
    put32(rtcm_pkg::ADR_ALM0, 32'h0000_0003);
    load(32'h0, B_OSC | B_RUN);
    n = alarm_rises;
    wr(rtcm_pkg::ADR_CTRL, B_OSC | B_RUN | B_AEN | B_ALM);
    tick(21);
    chk(alarm_rises - n, 4);
    chk(hi_max <= 8, 1'b1);
    // Stuck oscillator with the detector armed
    wr(rtcm_pkg::ADR_CTRL, B_OSC | B_LOSS);
    n = 0;
    while (n < 200 && loss !== 1'b1)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    if (n == 200)
      num_errors++;
    chk(n >= LOSS_N && n <= LOSS_N + 5, 1'b1);
    repeat (LOSS_N * 3) @(posedge clk);
    chk(loss_pulses, 1);
    rd(rtcm_pkg::ADR_CTRL, d);
    chk(d & B_FAIL, B_FAIL);
    wr(rtcm_pkg::ADR_CTRL, B_OSC | B_LOSS | B_FAIL);
    rd(rtcm_pkg::ADR_CTRL, d);
    chk(d & B_FAIL, B_FAIL);
    wr(rtcm_pkg::ADR_CTRL, B_OSC);
    rd(rtcm_pkg::ADR_CTRL, d);
    chk(d & B_FAIL, 8'h00);
    // Oscillator off
    wr(rtcm_pkg::ADR_CTRL, 8'h00);
    #1;
    chk(osc_en, 1'b0);
    test_done();
  end

endmodule
